// ### isp_lock_pkg.sv
// isp_lock_pkg: constants and carrier types for the service-program lock and entry block
// assumes a 16-bit flash address space and an AXI4-Lite register port with 32-bit data
`default_nettype none
package isp_lock_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_REGION = 4'h8;
  localparam logic [3:0] OFS_CONFIG = 4'hC;
  // control fields (write-one pulses)
  localparam int CTL_JUMP_SERVICE = 0;
  localparam int CTL_JUMP_ZERO = 1;
  // status field positions
  localparam int STS_FLAGS_LSB = 0;
  localparam int STS_COUNT_LSB = 4;
  localparam int STS_PROTECT = 9;
  localparam int STS_ENABLED = 10;
  localparam int STS_IN_SERVICE = 11;
  localparam int STS_PULSES_LSB = 12;
  // region geometry, erased and protected read bytes, entry pulse count
  localparam logic [4:0] COUNT_MAX = 5'h10;
  localparam logic [7:0] BLOCK_ZERO_LSB = 8'h00;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] PROTECTED_READ = 8'h00;
  localparam logic [1:0] PULSES_NEEDED = 2'h2;
  // reset values
  localparam logic [4:0] COUNT_RESET = 5'h00;
  localparam logic [7:0] ENTRY_EN_RESET = 8'h00;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // pin synchroniser width: strapA, strapB, strapC, clockDetect, porWindow, padWindow
  localparam int SYNC_W = 6;

  // flash operation kinds
  typedef enum logic [1:0] {
    OP_BYTE_PROGRAM,
    OP_PAGE_ERASE,
    OP_CHIP_ERASE,
    OP_NONE
  } flash_op_t;

  // one flash modify request
  typedef struct packed {
    logic valid;
    flash_op_t kind;
    logic [15:0] addr;
    logic [7:0] data;
  } flash_req_t;

  // latched nonvolatile configuration
  typedef struct packed {
    logic [4:0] count;
    logic protect;
    logic [7:0] entryEn;
  } nv_cfg_t;
endpackage : isp_lock_pkg
`default_nettype wire

// ### pin_sync.sv
// pin_sync: two-flop synchroniser for asynchronous pin levels
// assumes inputs are plain levels; only the second stage is read outside
`default_nettype none
module pin_sync (
  input wire logic clock, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic [isp_lock_pkg::SYNC_W-1:0] pinIn, // raw pin levels
  output logic [isp_lock_pkg::SYNC_W-1:0] pinOut // synchronised levels
);
  typedef struct packed {
    logic [isp_lock_pkg::SYNC_W-1:0] meta;
    logic [isp_lock_pkg::SYNC_W-1:0] stable;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  // each bit passes two flops; straps idle high so reset to ones
  always_comb begin
    state_nxt = state_r;
    for (int i = 0; i < isp_lock_pkg::SYNC_W; i++) begin
      state_nxt.meta[i] = pinIn[i];
      state_nxt.stable[i] = state_r.meta[i];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= '{meta: '1, stable: '1};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pinOut = state_r.stable;
endmodule : pin_sync
`default_nettype wire

// ### isp_space_lock_and_entry.sv
// isp_space_lock_and_entry: service-region lock, read protection and boot-entry decision
// assumes cpu and flash array on the same clock; straps and reset windows are async pins
`default_nettype none
module isp_space_lock_and_entry (
  input wire logic clock, // system clock, 250 MHz
  input wire logic reset, // synchronous, active high
  // hardware reset windows and pins (asynchronous)
  input wire logic porWindow, // power-on reset period active
  input wire logic padWindow, // pad reset period active
  input wire logic strap_input_a, // strap a, active low
  input wire logic strap_input_b, // strap b, active low
  input wire logic strap_input_c, // strap c, active low
  input wire logic clock_detect_input, // clock-detect pin
  // nonvolatile configuration and flash state
  input wire logic [4:0] nvLockCount, // configured block count
  input wire logic nvProtect, // read protection applied
  input wire logic [7:0] nvEntryEn, // selected entry mechanisms
  input wire logic [7:0] firstByte, // flash byte at address zero
  input wire logic powerDown, // cpu in power-down mode
  // cpu side
  input wire isp_lock_pkg::flash_req_t cpuReq, // modify request, one-cycle valid
  input wire logic cpuRdReq, // fetch/read request pulse
  input wire logic [15:0] cpuRdAddr, // read address
  output isp_lock_pkg::flash_req_t flashReq, // filtered request to array
  output logic [15:0] eraseKeepFrom, // chip erase spares from here up
  output logic reqRejected, // pulse: request dropped
  output logic flashRdReq, // read request to array
  output logic [15:0] flashRdAddr, // read address to array
  input wire logic [7:0] flashRdData, // array read data, same cycle as flashRdReq
  output logic cpuRdValid, // pulse: read data valid
  output logic [7:0] cpuRdData, // filtered read data
  output logic pcLoad, // pulse: load program counter
  output logic [15:0] pcLoadAddr, // program counter value
  output logic serviceMode, // executing service program
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read response valid
  input wire logic s_axi_rready // read response ready
);
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WINDOW,
    PH_RUN
  } phase_t;

  typedef struct packed {
    phase_t phase;
    isp_lock_pkg::nv_cfg_t cfg;
    logic porSeen;
    logic padSeen;
    logic [2:0] strapLow; // a, b, c sampled low
    logic clkPrev;
    logic [1:0] pulses;
    logic [3:0] flags;
    logic inService;
    logic [15:0] start;
    isp_lock_pkg::flash_req_t fReq;
    logic [15:0] keepFrom;
    logic rejected;
    logic rdReq;
    logic [15:0] rdAddr;
    logic rdPend;
    logic rdValid;
    logic [7:0] rdData;
    logic pcLoad;
    logic [15:0] pcAddr;
    logic awHeld;
    logic [3:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic [isp_lock_pkg::SYNC_W-1:0] pinsSync;

  // pins come from outside the clock domain; window pins enter inverted so that
  // the all-ones reset of the synchroniser reads as no window, not a false one
  pin_sync syncPins (
    .clock(clock),
    .reset(reset),
    .pinIn({!padWindow, !porWindow, clock_detect_input, strap_input_c, strap_input_b,
      strap_input_a}),
    .pinOut(pinsSync)
  );

  logic strapA;
  logic strapB;
  logic strapC;
  logic clkDet;
  logic porLvl;
  logic padLvl;
  assign strapA = pinsSync[0];
  assign strapB = pinsSync[1];
  assign strapC = pinsSync[2];
  assign clkDet = pinsSync[3];
  assign porLvl = !pinsSync[4];
  assign padLvl = !pinsSync[5];

  // helpers computed from state and inputs
  logic enabled;
  logic [15:0] regionStart;
  logic [3:0] cond;
  logic [3:0] fired;
  logic inRegion;
  logic doWrite;
  logic [31:0] statusWord;

  // region grows down from the top; wraps 0x10000 - N*256 in 16 bits
  always_comb begin
    enabled = (state_r.cfg.count != 5'h00) && (state_r.cfg.count <= isp_lock_pkg::COUNT_MAX);
    regionStart = 16'(ADDR_ZERO_EXT() - {3'b000, state_r.cfg.count, isp_lock_pkg::BLOCK_ZERO_LSB});
    inRegion = enabled && (cpuReq.addr >= regionStart);
    cond[0] = (firstByte == isp_lock_pkg::ERASED_BYTE);
    cond[1] = state_r.strapLow[0] && state_r.strapLow[1];
    cond[2] = state_r.strapLow[2];
    cond[3] = (state_r.pulses >= isp_lock_pkg::PULSES_NEEDED);
    statusWord = 32'h0000_0000;
    statusWord[isp_lock_pkg::STS_FLAGS_LSB +: 4] = state_r.flags;
    statusWord[isp_lock_pkg::STS_COUNT_LSB +: 5] = state_r.cfg.count;
    statusWord[isp_lock_pkg::STS_PROTECT] = state_r.cfg.protect;
    statusWord[isp_lock_pkg::STS_ENABLED] = enabled;
    statusWord[isp_lock_pkg::STS_IN_SERVICE] = state_r.inService;
    statusWord[isp_lock_pkg::STS_PULSES_LSB +: 2] = state_r.pulses;
    doWrite = state_r.awHeld && state_r.wHeld && !state_r.bValid;
  end

  // each mechanism pairs a condition with the resets seen while the window stood
  for (genvar k = 0; k < 4; k++) begin : gMech
    assign fired[k] = cond[k] && ((state_r.porSeen && state_r.cfg.entryEn[2*k]) ||
      (state_r.padSeen && state_r.cfg.entryEn[2*k+1]));
  end

  function automatic logic [16:0] ADDR_ZERO_EXT();
    ADDR_ZERO_EXT = {1'b1, isp_lock_pkg::ADDR_ZERO};
  endfunction : ADDR_ZERO_EXT

  // next-state logic for the whole block
  always_comb begin
    state_nxt = state_r;
    state_nxt.pcLoad = 1'b0;
    state_nxt.rejected = 1'b0;
    state_nxt.fReq.valid = 1'b0;
    state_nxt.rdReq = 1'b0;
    state_nxt.rdValid = 1'b0;
    state_nxt.clkPrev = clkDet;

    // reset-window sampling and boot decision
    case (state_r.phase)
      PH_IDLE, PH_RUN: begin
        if (porLvl || padLvl) begin
          state_nxt.phase = PH_WINDOW;
          state_nxt.porSeen = porLvl;
          state_nxt.padSeen = padLvl;
          state_nxt.pulses = 2'h0;
          state_nxt.flags = 4'h0;
          state_nxt.inService = 1'b0;
        end
      end
      PH_WINDOW: begin
        // configuration only moves while a hardware reset is held
        state_nxt.cfg = '{count: nvLockCount, protect: nvProtect, entryEn: nvEntryEn};
        state_nxt.strapLow = {!strapC, !strapB, !strapA};
        state_nxt.porSeen = state_r.porSeen || porLvl;
        state_nxt.padSeen = state_r.padSeen || padLvl;
        if (clkDet && !state_r.clkPrev && state_r.pulses != 2'h3) begin
          state_nxt.pulses = 2'(state_r.pulses + 2'h1);
        end
        if (!porLvl && !padLvl) begin
          // window closed: choose boot address
          state_nxt.phase = PH_RUN;
          state_nxt.pcLoad = 1'b1;
          if (enabled && !powerDown && (fired != 4'h0)) begin
            state_nxt.flags = fired;
            state_nxt.inService = 1'b1;
            state_nxt.pcAddr = regionStart;
          end else begin
            state_nxt.pcAddr = isp_lock_pkg::ADDR_ZERO;
          end
        end
      end
      default: begin
        state_nxt.phase = PH_IDLE;
      end
    endcase
    state_nxt.start = regionStart;

    // modify requests: the region is out of reach from inside the chip
    if (cpuReq.valid) begin
      state_nxt.fReq = cpuReq;
      state_nxt.keepFrom = enabled ? regionStart : isp_lock_pkg::ADDR_ZERO;
      if (cpuReq.kind == isp_lock_pkg::OP_CHIP_ERASE) begin
        state_nxt.fReq.valid = 1'b1;
      end else if (cpuReq.kind == isp_lock_pkg::OP_NONE || inRegion) begin
        state_nxt.fReq.valid = 1'b0;
        state_nxt.rejected = 1'b1;
      end
    end

    // reads: array answers next cycle, protection forces zero
    state_nxt.rdPend = cpuRdReq;
    if (cpuRdReq) begin
      state_nxt.rdReq = 1'b1;
      state_nxt.rdAddr = cpuRdAddr;
    end
    if (state_r.rdPend) begin
      state_nxt.rdValid = 1'b1;
      state_nxt.rdData = state_r.cfg.protect ? isp_lock_pkg::PROTECTED_READ : flashRdData;
    end

    // axi write channel: address and data taken in either order
    if (s_axi_awvalid && !state_r.awHeld && !state_r.bValid) begin
      state_nxt.awHeld = 1'b1;
      state_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_r.wHeld && !state_r.bValid) begin
      state_nxt.wHeld = 1'b1;
      state_nxt.wData = s_axi_wdata;
      state_nxt.wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      state_nxt.awHeld = 1'b0;
      state_nxt.wHeld = 1'b0;
      state_nxt.bValid = 1'b1;
      state_nxt.bResp = isp_lock_pkg::RESP_OKAY;
      case (state_r.awAddr)
        isp_lock_pkg::OFS_CONTROL: begin
          if (state_r.wStrb[0] && state_r.wData[isp_lock_pkg::CTL_JUMP_ZERO]) begin
            state_nxt.pcLoad = 1'b1;
            state_nxt.pcAddr = isp_lock_pkg::ADDR_ZERO;
            state_nxt.inService = 1'b0;
          end else if (state_r.wStrb[0] && state_r.wData[isp_lock_pkg::CTL_JUMP_SERVICE] &&
              enabled && !powerDown) begin
            state_nxt.pcLoad = 1'b1;
            state_nxt.pcAddr = regionStart;
            state_nxt.inService = 1'b1;
          end
        end
        isp_lock_pkg::OFS_STATUS, isp_lock_pkg::OFS_REGION, isp_lock_pkg::OFS_CONFIG: begin
          state_nxt.bResp = isp_lock_pkg::RESP_OKAY; // read-only, write ignored
        end
        default: begin
          state_nxt.bResp = isp_lock_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_r.bValid && s_axi_bready) begin
      state_nxt.bValid = 1'b0;
    end

    // axi read channel: one cycle from address to data
    if (s_axi_arvalid && !state_r.rValid) begin
      state_nxt.rValid = 1'b1;
      state_nxt.rResp = isp_lock_pkg::RESP_OKAY;
      case (s_axi_araddr)
        isp_lock_pkg::OFS_CONTROL: state_nxt.rData = 32'h0000_0000;
        isp_lock_pkg::OFS_STATUS: state_nxt.rData = statusWord;
        isp_lock_pkg::OFS_REGION: state_nxt.rData = {16'h0000, regionStart};
        isp_lock_pkg::OFS_CONFIG: state_nxt.rData = {24'h00_0000, state_r.cfg.entryEn};
        default: begin
          state_nxt.rData = 32'h0000_0000;
          state_nxt.rResp = isp_lock_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state_r.rValid && s_axi_rready) begin
      state_nxt.rValid = 1'b0;
    end
  end

  // one register bank for all state
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= '0;
      state_r.phase <= PH_IDLE;
      state_r.cfg <= '{count: isp_lock_pkg::COUNT_RESET, protect: 1'b0,
        entryEn: isp_lock_pkg::ENTRY_EN_RESET};
      state_r.fReq.kind <= isp_lock_pkg::OP_NONE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // every output straight from a flop, except the three ready outputs, which are gated from flops
  assign flashReq = state_r.fReq;
  assign eraseKeepFrom = state_r.keepFrom;
  assign reqRejected = state_r.rejected;
  assign flashRdReq = state_r.rdReq;
  assign flashRdAddr = state_r.rdAddr;
  assign cpuRdValid = state_r.rdValid;
  assign cpuRdData = state_r.rdData;
  assign pcLoad = state_r.pcLoad;
  assign pcLoadAddr = state_r.pcAddr;
  assign serviceMode = state_r.inService;
  assign s_axi_awready = !state_r.awHeld && !state_r.bValid;
  assign s_axi_wready = !state_r.wHeld && !state_r.bValid;
  assign s_axi_bvalid = state_r.bValid;
  assign s_axi_bresp = state_r.bResp;
  assign s_axi_arready = !state_r.rValid;
  assign s_axi_rvalid = state_r.rValid;
  assign s_axi_rdata = state_r.rData;
  assign s_axi_rresp = state_r.rResp;
endmodule : isp_space_lock_and_entry
`default_nettype wire

// ### isp_lock_properties.sv
// isp_lock_properties: port-level checks of the lock and entry block
// assumes one clock domain; bound onto every instance of the block
`default_nettype none
module isp_lock_properties (
  input wire logic clock, // system clock
  input wire logic reset, // sync reset
  input wire logic porWindow, // power-on window
  input wire logic padWindow, // pad window
  input wire logic [4:0] nvLockCount, // configured count
  input wire isp_lock_pkg::flash_req_t cpuReq, // cpu modify
  input wire logic cpuRdReq, // cpu read
  input wire logic [15:0] cpuRdAddr, // read address
  input wire isp_lock_pkg::flash_req_t flashReq, // to array
  input wire logic reqRejected, // drop pulse
  input wire logic flashRdReq, // array read
  input wire logic [15:0] flashRdAddr, // array address
  input wire logic cpuRdValid, // read done
  input wire logic pcLoad, // pc load pulse
  input wire logic [15:0] pcLoadAddr, // pc value
  input wire logic serviceMode, // service level
  input wire logic [15:0] eraseKeepFrom // region start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // count as taken while a reset window stands, for the entry address
  logic [4:0] cfgCount;
  always_ff @(posedge clock) begin
    if (porWindow || padWindow) begin
      cfgCount <= nvLockCount;
    end
  end
  // a window of at least four cycles, then its release
  sequence win_s;
    (porWindow || padWindow) [*4] ##1 !(porWindow || padWindow);
  endsequence
  // fetch passes through the array in two steps
  sequence fetch_s;
    ##1 flashRdReq ##1 cpuRdValid;
  endsequence
  a_modify_answer: assert property (cpuReq.valid |=> flashReq.valid != reqRejected)
    else $error("modify request got no single answer");
  a_region_drop: assert property (cpuReq.valid && eraseKeepFrom != 16'h0000
    && cpuReq.kind inside {isp_lock_pkg::OP_BYTE_PROGRAM, isp_lock_pkg::OP_PAGE_ERASE}
    && cpuReq.addr >= eraseKeepFrom |=> reqRejected)
    else $error("change inside service region not dropped");
  a_erase_kept: assert property (cpuReq.valid && cpuReq.kind == isp_lock_pkg::OP_CHIP_ERASE
    |=> flashReq.valid && flashReq.kind == isp_lock_pkg::OP_CHIP_ERASE)
    else $error("chip erase not forwarded");
  a_read_path: assert property (cpuRdReq |-> fetch_s)
    else $error("read did not pass through array");
  a_read_addr: assert property (cpuRdReq |=> flashRdAddr == $past(cpuRdAddr))
    else $error("read address changed on the way");
  a_region_shape: assert property (eraseKeepFrom[7:0] == 8'h00
    && (eraseKeepFrom == 16'h0000 || eraseKeepFrom >= 16'hF000))
    else $error("region start off the block grid");
  a_entry_addr: assert property (pcLoad && pcLoadAddr != 16'h0000
    |-> pcLoadAddr == 16'(17'h10000 - {cfgCount, 8'h00}))
    else $error("entry address is not the region start");
  a_mode_level: assert property (pcLoad |=> serviceMode == (pcLoadAddr != 16'h0000))
    else $error("service level disagrees with pc load");
  a_pc_pulse: assert property (pcLoad |=> !pcLoad)
    else $error("pc load longer than one cycle");
  a_close_load: assert property (win_s |-> ##[1:6] pcLoad)
    else $error("no boot decision after reset window");
endmodule : isp_lock_properties
bind isp_space_lock_and_entry isp_lock_properties chk (.clock, .reset, .porWindow, .padWindow,
  .nvLockCount,
  .cpuReq, .cpuRdReq, .cpuRdAddr, .flashReq, .reqRejected, .flashRdReq, .flashRdAddr,
  .cpuRdValid, .pcLoad, .pcLoadAddr, .serviceMode, .eraseKeepFrom);
`default_nettype wire

// ### flash_read_model.sv
// flash_read_model: behavioural read port of the flash array
// assumes one read per pulse; data valid only while the pulse stands
`default_nettype none
module flash_read_model (
  input wire logic clock, // system clock
  input wire logic reset, // sync reset
  input wire logic flashRdReq, // read pulse
  input wire logic [15:0] flashRdAddr, // read address
  output logic [7:0] flashRdData // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lastData;
  // array answers while the pulse stands; block samples it at the next edge
  always_ff @(posedge clock) begin
    if (reset) begin
      lastData <= 8'h00;
    end else if (flashRdReq) begin
      lastData <= flashRdAddr[15:8] ^ flashRdAddr[7:0];
    end
  end
  // released bus shows the inverse so a late sample cannot match by luck
  assign flashRdData = flashRdReq ? (flashRdAddr[15:8] ^ flashRdAddr[7:0]) : ~lastData;
endmodule : flash_read_model
`default_nettype wire

// ### isp_space_lock_and_entry_test.sv
// isp_space_lock_and_entry_test: self-checking bench for lock and entry
// assumes flash_read_model on the array side and bound port checks
`default_nettype none
module isp_space_lock_and_entry_test;
  timeunit 1ns;
  timeprecision 1ps;
  // one reset-entry case and the boot address it should give
  typedef struct {
    logic por; logic [4:0] n; logic [7:0] en, fb; logic [2:0] strap;
    logic [1:0] pul; logic pd, prot; logic [15:0] exp;
  } row_t;
  logic clock, reset, porWindow, padWindow, strap_input_a, strap_input_b, strap_input_c;
  logic clock_detect_input, nvProtect, powerDown, cpuRdReq, reqRejected, flashRdReq;
  logic cpuRdValid, pcLoad, serviceMode, s_axi_awready, s_axi_awvalid, s_axi_wready;
  logic s_axi_wvalid, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [4:0] nvLockCount;
  logic [7:0] nvEntryEn, firstByte, flashRdData, cpuRdData;
  logic [15:0] cpuRdAddr, flashRdAddr, eraseKeepFrom, pcLoadAddr, pc, st, rd;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  isp_lock_pkg::flash_req_t cpuReq, flashReq;
  isp_lock_pkg::flash_op_t kd[4] = '{isp_lock_pkg::OP_BYTE_PROGRAM,
    isp_lock_pkg::OP_PAGE_ERASE, isp_lock_pkg::OP_CHIP_ERASE, isp_lock_pkg::OP_NONE};
  logic [15:0] ad[4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic rj[4] = '{1'h0, 1'h0, 1'h0, 1'h1};
  int failures = 0, n_checks = 0, cyc = 0, i, j, k;
  // por,n,en,firstByte,straps abc,pulses,powerDown,protect,boot address
  row_t rows[14] = '{
    '{1'h1, 5'h01, 8'h01, 8'hFF, 3'h7, 2'h0, 1'h0, 1'h0, 16'hFF00},
    '{1'h0, 5'h02, 8'h02, 8'hFF, 3'h7, 2'h0, 1'h0, 1'h1, 16'hFE00},
    '{1'h1, 5'h10, 8'h04, 8'h00, 3'h1, 2'h0, 1'h0, 1'h0, 16'hF000},
    '{1'h0, 5'h03, 8'h08, 8'h00, 3'h1, 2'h0, 1'h0, 1'h0, 16'hFD00},
    '{1'h1, 5'h04, 8'h10, 8'h00, 3'h6, 2'h0, 1'h0, 1'h0, 16'hFC00},
    '{1'h0, 5'h05, 8'h20, 8'h00, 3'h6, 2'h0, 1'h0, 1'h1, 16'hFB00},
    '{1'h1, 5'h06, 8'h40, 8'h00, 3'h7, 2'h2, 1'h0, 1'h0, 16'hFA00},
    '{1'h0, 5'h07, 8'h80, 8'h00, 3'h7, 2'h2, 1'h0, 1'h0, 16'hF900},
    '{1'h1, 5'h00, 8'hFF, 8'hFF, 3'h0, 2'h2, 1'h0, 1'h0, 16'h0000},
    '{1'h1, 5'h08, 8'h02, 8'hFF, 3'h7, 2'h0, 1'h0, 1'h0, 16'h0000},
    '{1'h1, 5'h09, 8'h40, 8'h00, 3'h7, 2'h1, 1'h0, 1'h0, 16'h0000},
    '{1'h1, 5'h0F, 8'hFF, 8'hFF, 3'h0, 2'h0, 1'h1, 1'h0, 16'h0000},
    '{1'h0, 5'h0B, 8'h08, 8'h00, 3'h3, 2'h0, 1'h0, 1'h0, 16'h0000},
    '{1'h1, 5'h11, 8'hFF, 8'hFF, 3'h0, 2'h0, 1'h0, 1'h0, 16'h0000}};

  isp_space_lock_and_entry dut (.*);
  flash_read_model model (.*);

  // 250 MHz clock
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  // hang guard; a run takes a few hundred cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  function automatic logic [15:0] region_start(input logic [4:0] n);
    return (n != 5'h00 && n <= 5'h10) ? 16'h0000 - {3'h0, n, 8'h00} : 16'h0000;
  endfunction : region_start

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task tally_and_finish();
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // address and data offered together, each dropped once taken
  task axw(input logic [3:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      if (!aw && !w && s_axi_bvalid) break;
      if (s_axi_awready) aw = 1'h0;
      if (s_axi_wready) w = 1'h0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'h0;
    check({s_axi_bvalid, s_axi_bresp}, {1'h1, isp_lock_pkg::RESP_OKAY});
  endtask : axw

  task axr(input logic [3:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    // rready stays up: the next read raises it again at once
    v = s_axi_rdata;
    check({s_axi_rvalid, s_axi_rresp}, {1'h1, isp_lock_pkg::RESP_OKAY});
  endtask : axr

  // one hardware reset window with straps and pulses, then the boot decision
  task win(input row_t r, output logic [15:0] p);
    nvLockCount <= r.n;
    nvProtect <= r.prot;
    nvEntryEn <= r.en;
    firstByte <= r.fb;
    {strap_input_a, strap_input_b, strap_input_c} <= r.strap;
    powerDown <= r.pd;
    porWindow <= r.por;
    padWindow <= !r.por;
    repeat (6) @(posedge clock);
    for (k = 0; k < 2 * r.pul; k++) begin
      clock_detect_input <= !clock_detect_input;
      repeat (3) @(posedge clock);
    end
    {porWindow, padWindow} <= 2'h0;
    p = 16'h1234;
    for (k = 0; k < 12; k++) begin
      @(posedge clock);
      if (pcLoad) begin
        p = pcLoadAddr;
        break;
      end
    end
    {strap_input_a, strap_input_b, strap_input_c, powerDown} <= 4'hE;
  endtask : win

  task jump(input logic [31:0] v, input logic [16:0] e);
    axw(isp_lock_pkg::OFS_CONTROL, v);
    repeat (3) @(posedge clock);
    check({serviceMode, pcLoadAddr}, e);
  endtask : jump

  // main sequence
  initial begin
    {reset, porWindow, padWindow, clock_detect_input, nvProtect, powerDown} = 6'h20;
    {strap_input_a, strap_input_b, strap_input_c} = 3'h7;
    {nvLockCount, nvEntryEn, firstByte, cpuRdReq, cpuRdAddr} = '0;
    {cpuReq, s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    check({serviceMode, eraseKeepFrom, pcLoad, s_axi_awready}, 19'h00001);
    for (i = 0; i < 14; i++) begin
      win(rows[i], pc);
      st = region_start(rows[i].n);
      check(pc, rows[i].exp);
      ad[0] = st;
      ad[1] = st - 16'h0001;
      rj[0] = st != 16'h0000;
      for (j = 0; j < 6; j++) begin
        @(posedge clock);
        cpuReq <= (j < 4) ? {1'h1, kd[j], ad[j], 8'h5A} : '0;
        if (j > 1) check(reqRejected, rj[j - 2]);
        if (j > 1 && !rj[j - 2]) check(flashReq, {1'h1, kd[j - 2], ad[j - 2], 8'h5A});
      end
      // keep-from address follows each request, so look after them
      check(eraseKeepFrom, st);
      rd = rj[0] ? st : 16'h0100;
      cpuRdReq <= 1'h1;
      cpuRdAddr <= rd;
      @(posedge clock);
      cpuRdReq <= 1'h0;
      for (k = 0; k < 8 && !cpuRdValid; k++) @(posedge clock);
      check({cpuRdValid, cpuRdData}, {1'h1, rows[i].prot ? 8'h00 : rd[15:8] ^ rd[7:0]});
      axr(isp_lock_pkg::OFS_CONFIG, d);
      check(d, {24'h0, rows[i].en});
      axr(isp_lock_pkg::OFS_STATUS, d);
      check({d[11:4], serviceMode},
        {rows[i].exp != 0, st != 16'h0, rows[i].prot, rows[i].n, rows[i].exp != 0});
      check(d[13:12], rows[i].pul);
      check(d[3:0] != 4'h0, rows[i].exp != 0);
    end
    // no mechanism fires, then software jumps in and out
    win('{1'h1, 5'h04, 8'h00, 8'h00, 3'h7, 2'h0, 1'h0, 1'h0, 16'h0}, pc);
    check(pc, 16'h0000);
    jump(32'h1, {1'h1, 16'hFC00});
    jump(32'h3, {1'h0, 16'h0000});
    powerDown <= 1'h1;
    jump(32'h1, {1'h0, 16'h0000});
    powerDown <= 1'h0;
    // configuration must not follow the pins outside a window
    nvLockCount <= 5'h01;
    cpuReq <= {1'h1, isp_lock_pkg::OP_CHIP_ERASE, 24'h0};
    @(posedge clock);
    cpuReq <= '0;
    axw(isp_lock_pkg::OFS_REGION, 32'h0);
    axr(isp_lock_pkg::OFS_REGION, d);
    check(d, 32'h0000FC00);
    check(eraseKeepFrom, 16'hFC00);
    jump(32'h1, {1'h1, 16'hFC00});
    // reset in mid-run drops service mode and configuration
    reset <= 1'h1;
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    check({serviceMode, eraseKeepFrom, s_axi_awready}, 18'h00001);
    tally_and_finish();
  end
endmodule : isp_space_lock_and_entry_test
`default_nettype wire
